//--- apc_host.sv
// Purpose: host end: start strobe, register writes, result reads
// Assumes: one command at a time; cmd_valid taken only when cmd_ready
// Notes:   write strobe lasts one clk cycle, read strobe three
`timescale 1ns/1ps
`default_nettype none
module apc_host (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 cmd_valid,
    input  wire logic [1:0]           cmd_op,
    input  wire logic [11:0]          cmd_data,
    input  wire logic                 cmd_word_mode,
    apc_if.host                       port,
    output logic                      cmd_ready,
    output logic                      rsp_valid,
    output logic [11:0]               rsp_data,
    output logic [2:0]                rsp_channel
);
    // cmd_op: 0 convert, 1 write, 2 read
    typedef enum logic [2:0] {H_IDLE, H_WAKE, H_START, H_WAIT,
                              H_ACC, H_ACC2, H_ACC3, H_END} apc_hst_t;
    typedef struct packed {
        apc_hst_t    state;
        logic [1:0]  op;
        logic [11:0] data;
        logic        wm;
        logic        hb;
        logic        conv_n;
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic [11:0] hout;
        logic        hoe;
        logic        rvalid;
        logic [11:0] rdata;
        logic [2:0]  rch;
        logic        ready;
    } apc_host_st_t;

    apc_host_st_t st_r;
    apc_host_st_t st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = 1'b0;
        case (st_r.state)
            H_IDLE: begin
                if (cmd_valid) begin
                    st_nxt.op    = cmd_op;
                    st_nxt.data  = cmd_data;
                    st_nxt.wm    = cmd_word_mode;
                    st_nxt.hb    = 1'b0;
                    st_nxt.ready = 1'b0;
                    st_nxt.state = (cmd_op == 2'h0) ? H_WAKE : H_ACC;
                    st_nxt.conv_n = (cmd_op == 2'h0) ? 1'b0 : st_r.conv_n;
                end
            end
            H_WAKE: begin
                st_nxt.conv_n = 1'b1;
                st_nxt.state  = H_START;
            end
            H_START: begin
                st_nxt.conv_n = 1'b0;
                st_nxt.state  = H_WAIT;
            end
            H_WAIT: begin
                if (port.busy) begin
                    st_nxt.conv_n = 1'b1;
                end
                if (!port.busy && st_r.conv_n) begin
                    st_nxt.state = H_END;
                end
            end
            H_ACC: begin
                st_nxt.cs_n = 1'b0;
                if (st_r.op == 2'h1) begin
                    st_nxt.wr_n = 1'b0;
                    st_nxt.hoe  = 1'b1;
                    if (st_r.wm) begin
                        st_nxt.hout = st_r.data;
                    end else if (st_r.hb) begin
                        st_nxt.hout = {3'h0, 1'b1, apc_pkg::HB_ZERO, st_r.data[11:8]};
                    end else begin
                        st_nxt.hout = {3'h0, 1'b0, st_r.data[7:0]};
                    end
                end else begin
                    st_nxt.rd_n = 1'b0;
                    st_nxt.hoe  = ~st_r.wm; // byte mode drives all host bits: bit 8 select, the others zero
                    st_nxt.hout = {3'h0, st_r.hb, 8'h00};
                end
                st_nxt.state = H_ACC2;
            end
            H_ACC2: begin
                // device drives one cycle after it sees the strobe: reads wait here once
                if (st_r.op == 2'h1) begin
                    st_nxt.wr_n  = 1'b1;
                    st_nxt.cs_n  = 1'b1;
                    st_nxt.hoe   = 1'b0;
                    st_nxt.state = H_END;
                end else begin
                    st_nxt.state = H_ACC3;
                end
            end
            H_ACC3: begin
                // strobes still low, so the word sampled here is still driven
                if (st_r.wm) begin
                    st_nxt.rdata = port.bus;
                end else if (st_r.hb) begin
                    st_nxt.rdata[11:8] = port.bus[3:0];
                    st_nxt.rch         = port.bus[6:4];
                end else begin
                    st_nxt.rdata[7:0] = port.bus[7:0];
                end
                st_nxt.state = H_END;
            end
            H_END: begin
                st_nxt.cs_n = 1'b1;
                st_nxt.rd_n = 1'b1;
                st_nxt.hoe  = 1'b0;
                if (!st_r.wm && !st_r.hb && st_r.op != 2'h0) begin
                    st_nxt.hb    = 1'b1; // second byte
                    st_nxt.state = H_ACC;
                end else begin
                    st_nxt.rvalid = 1'b1;
                    st_nxt.ready  = 1'b1;
                    st_nxt.state  = H_IDLE;
                end
            end
            default: begin
                st_nxt.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{state: H_IDLE, op: 2'h0, data: 12'h000, wm: 1'b1, hb: 1'b0,
                      conv_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, hout: 12'h000,
                      hoe: 1'b0, rvalid: 1'b0, rdata: 12'h000, rch: 3'h0, ready: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port.conversion_start_n = st_r.conv_n;
    assign port.chip_select_n      = st_r.cs_n;
    assign port.read_n             = st_r.rd_n;
    assign port.write_n            = st_r.wr_n;
    assign port.word_mode          = st_r.wm;
    assign port.host_dout          = st_r.hout;
    assign port.host_doe           = st_r.hoe;
    assign cmd_ready               = st_r.ready;
    assign rsp_valid               = st_r.rvalid;
    assign rsp_data                = st_r.rdata;
    assign rsp_channel             = st_r.rch;
endmodule // apc_host
`default_nettype wire

//--- apc_pkg.sv
// Purpose: shared constants and types for the converter control port
// Assumes: one system clock; master clock and strobes sampled as inputs
// Notes:   widths and counts fixed
`default_nettype none
package apc_pkg;
    localparam int unsigned DATA_W     = 12;
    localparam int unsigned BUS_W      = 12;
    localparam int unsigned CHAN_W     = 3;
    localparam int unsigned CONV_EDGES = 13;
    localparam int unsigned CNT_W      = 4;
    localparam logic [3:0]  HB_ZERO    = 4'h0;
    localparam int unsigned HB_ID_LSB  = 4;
    localparam int unsigned CTRL_W     = 12;
    // control word field positions (low three bits pick the channel)
    localparam int unsigned CH_LSB     = 0;
    localparam int unsigned PWR_BIT    = 3;
    localparam logic [11:0] CTRL_RST   = 12'h000;
    localparam logic [11:0] RES_RST    = 12'h000;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} apc_state_t;
endpackage
`default_nettype wire

//--- apc_if.sv
// Purpose: parallel bus between host and converter port
// Assumes: wire level resolved from the enables
// Notes:   one modport per party
`timescale 1ns/1ps
`default_nettype none
interface apc_if;
    logic        conversion_start_n;
    logic        chip_select_n;
    logic        read_n;
    logic        write_n;
    logic        word_mode;
    logic        busy;
    logic [11:0] dev_dout;
    logic [11:0] dev_doe;
    logic [11:0] host_dout;
    logic        host_doe;
    logic [11:0] bus;
    // bit 8 doubles as high_byte_select when word_mode is low
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (dev_doe[i]) begin
                bus[i] = dev_dout[i];
            end else if (host_doe) begin
                bus[i] = host_dout[i];
            end else begin
                bus[i] = 1'b0;
            end
        end
    end
    modport dev (input conversion_start_n, chip_select_n, read_n, write_n, word_mode, bus,
                 output busy, dev_dout, dev_doe);
    modport host (input busy, bus,
                  output conversion_start_n, chip_select_n, read_n, write_n, word_mode,
                         host_dout, host_doe);
endinterface
`default_nettype wire

//--- apc_dev.sv
// Purpose: converter end: conversion timing, result and register port
// Assumes: master clock, strobes and bus synchronous to clk
// Notes:   conversion data is taken from sample_data at result time
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - start falling edge holds sample, starts conversion
// - start rising edge wakes from auto power-down
// - busy high during conversion, low with result
// - track resumes on thirteenth master clock rising
// - conversion is thirteen master clocks plus setup
// - continuous or burst master clock both work
// - word mode: bit 8 data, else byte select
// - byte select picks low byte or top nibble
// - host zeroes bits 4-7 on high-byte writes
// - three-state bus, bits 9-11 word mode only
// - write strobe with select stores register value
// - read strobe with select drives result
module apc_dev (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 master_clk,
    input  wire logic [11:0]          sample_data,
    apc_if.dev                        port,
    output logic                      tracking,
    output logic                      powered_up,
    output logic [11:0]               ctrl_word,
    output logic                      ctrl_strobe
);
    typedef struct packed {
        apc_pkg::apc_state_t state;
        logic [3:0]          cnt;
        logic                conv_d;
        logic                mclk_d;
        logic                wr_d;
        logic                hold;
        logic                pwr;
        logic                busy;
        logic [11:0]         result;
        logic [2:0]          res_ch;
        logic [11:0]         ctrl;
        logic                ctrl_stb;
        logic [11:0]         dout;
        logic [11:0]         doe;
    } apc_dev_st_t;

    apc_dev_st_t st_r;
    apc_dev_st_t st_nxt;

    // ------------------------------------------------------------
    // reset image
    // ------------------------------------------------------------
    // edge history at the idle pin levels, so no false edge follows reset
    localparam apc_dev_st_t ST_RST = '{
        state:    apc_pkg::ST_IDLE,
        cnt:      4'h0,
        conv_d:   1'b1,
        mclk_d:   1'b0,
        wr_d:     1'b1,
        hold:     1'b0,
        pwr:      1'b1,
        busy:     1'b0,
        result:   apc_pkg::RES_RST,
        res_ch:   3'h0,
        ctrl:     apc_pkg::CTRL_RST,
        ctrl_stb: 1'b0,
        dout:     12'h000,
        doe:      12'h000
    };

    logic        conv_fall;
    logic        conv_rise;
    logic        mclk_rise;
    logic        wr_fall;
    logic        hb_sel;
    logic        rd_act;
    logic [11:0] rd_word;
    logic [11:0] rd_high;
    logic [11:0] rd_low;

    // ------------------------------------------------------------
    // strobe edges, one clk wide; read and byte-select levels
    // ------------------------------------------------------------
    // every pin is sampled on clk, so an edge is old level against new level
    assign conv_fall = st_r.conv_d & ~port.conversion_start_n;
    assign conv_rise = ~st_r.conv_d & port.conversion_start_n;
    assign mclk_rise = ~st_r.mclk_d & master_clk;
    // write taken once per strobe: a strobe held low stores nothing twice
    assign wr_fall   = st_r.wr_d & ~port.write_n & ~port.chip_select_n;
    assign hb_sel    = ~port.word_mode & port.bus[8];
    assign rd_act    = ~port.chip_select_n & ~port.read_n;

    // ------------------------------------------------------------
    // read words for each bus mode
    // ------------------------------------------------------------
    assign rd_word = st_r.result;
    // top nibble with the channel of the stored result above it
    assign rd_high = {5'h00, st_r.res_ch, st_r.result[11:8]};
    assign rd_low  = {4'h0, st_r.result[7:0]};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt          = st_r;
        st_nxt.conv_d   = port.conversion_start_n;
        st_nxt.mclk_d   = master_clk;
        st_nxt.wr_d     = port.write_n | port.chip_select_n;
        st_nxt.ctrl_stb = 1'b0;
        if (conv_rise) begin
            st_nxt.pwr = 1'b1;
        end
        // ------------------------------------------------------------
        // conversion sequencer
        // ------------------------------------------------------------
        // only clock edges counted: a burst clock that stops between conversions is fine
        case (st_r.state)
            apc_pkg::ST_IDLE: begin
                // a fall while powered down is dropped: the host wakes first
                if (conv_fall && st_r.pwr) begin
                    st_nxt.state = apc_pkg::ST_CONV;
                    st_nxt.hold  = 1'b1;
                    st_nxt.busy  = 1'b1;
                    st_nxt.cnt   = '0;
                end
            end
            apc_pkg::ST_CONV: begin
                if (mclk_rise) begin
                    st_nxt.cnt = st_r.cnt + 4'h1;
                    if (st_r.cnt == 4'(apc_pkg::CONV_EDGES - 1)) begin
                        st_nxt.hold   = 1'b0;
                        st_nxt.result = sample_data;
                        st_nxt.res_ch = st_r.ctrl[apc_pkg::CH_LSB +: apc_pkg::CHAN_W];
                        st_nxt.state  = apc_pkg::ST_DONE;
                    end
                end
            end
            apc_pkg::ST_DONE: begin
                // busy falls one cycle after track resumes, result already stored
                st_nxt.busy  = 1'b0;
                st_nxt.state = apc_pkg::ST_IDLE;
                // auto power-down; a wake rise in this same cycle wins
                if (st_r.ctrl[apc_pkg::PWR_BIT] && !conv_rise) begin
                    st_nxt.pwr = 1'b0;
                end
            end
            default: begin
                st_nxt.state = apc_pkg::ST_IDLE;
            end
        endcase
        // ------------------------------------------------------------
        // register write
        // ------------------------------------------------------------
        if (wr_fall) begin
            st_nxt.ctrl_stb = 1'b1;
            if (port.word_mode) begin
                st_nxt.ctrl = port.bus;
            end else if (hb_sel) begin
                st_nxt.ctrl[11:8] = port.bus[3:0];
            end else begin
                st_nxt.ctrl[7:0] = port.bus[7:0];
            end
        end
        // ------------------------------------------------------------
        // read drive
        // ------------------------------------------------------------
        st_nxt.doe  = '0;
        st_nxt.dout = '0;
        if (rd_act) begin
            if (port.word_mode) begin
                st_nxt.doe  = 12'hFFF;
                st_nxt.dout = rd_word;
            end else if (hb_sel) begin
                // bit 8 stays with the host in byte mode: it is the byte select
                st_nxt.doe  = 12'h0FF;
                st_nxt.dout = rd_high;
            end else begin
                st_nxt.doe  = 12'h0FF;
                st_nxt.dout = rd_low;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // all outputs come straight off the state register
    assign port.busy     = st_r.busy;
    assign port.dev_dout = st_r.dout;
    assign port.dev_doe  = st_r.doe;
    assign tracking      = ~st_r.hold;
    assign powered_up    = st_r.pwr;
    assign ctrl_word     = st_r.ctrl;
    assign ctrl_strobe   = st_r.ctrl_stb;
endmodule // apc_dev
`default_nettype wire

//--- apc_asserts.sv
// Purpose: timing checks on the host/converter bus
// Assumes: one clock domain, master clock sampled as a level on clk
// Notes:   master clock period spans several clk cycles
`timescale 1ns/1ps
`default_nettype none
module apc_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        master_clk,
    input wire logic        conversion_start_n,
    input wire logic        chip_select_n,
    input wire logic        read_n,
    input wire logic        write_n,
    input wire logic        word_mode,
    input wire logic        busy,
    input wire logic [11:0] dev_dout,
    input wire logic [11:0] dev_doe,
    input wire logic [11:0] bus
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // master clock rises seen while busy
    // ------------------------------------------------------------
    logic       mclk_q_r;
    logic [4:0] rise_cnt_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mclk_q_r   <= 1'b0;
            rise_cnt_r <= 5'h00;
        end else begin
            mclk_q_r   <= master_clk;
            if (!busy) begin
                rise_cnt_r <= 5'h00;
            end else if (master_clk && !mclk_q_r) begin
                rise_cnt_r <= rise_cnt_r + 5'h01;
            end
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    busy_start_a: assert property ($rose(busy) |-> $past(conversion_start_n, 2) &&
        !$past(conversion_start_n)) else $error("busy rose without a start fall");
    busy_len_a: assert property ($fell(busy) |-> rise_cnt_r == 5'h0D)
        else $error("conversion length not thirteen master clocks");
    busy_hold_a: assert property ($rose(busy) |-> busy [*8])
        else $error("busy dropped early");
    bus_release_a: assert property ((chip_select_n || read_n) [*2] |-> dev_doe == 12'h000)
        else $error("bus driven outside a read");
    word_drive_a: assert property ((!chip_select_n && !read_n && word_mode) [*2]
        |-> dev_doe == 12'hFFF) else $error("word read not driving all bits");
    byte_drive_a: assert property ((!chip_select_n && !read_n && !word_mode) [*2]
        |-> dev_doe[7:0] == 8'hFF && dev_doe[11:8] == 4'h0)
        else $error("byte read drives wrong bits");
    read_stable_a: assert property ((!chip_select_n && !read_n) [*3] |-> $stable(dev_dout))
        else $error("read data changed during read");
    hb_write_zero_a: assert property (!chip_select_n && !write_n && !word_mode && bus[8]
        |-> bus[7:4] == 4'h0) else $error("high byte write with upper bits set");
    strobe_sel_a: assert property (!read_n || !write_n |-> !chip_select_n)
        else $error("strobe without chip select");
    cover property ($fell(busy));
    cover property (!chip_select_n && !read_n && !word_mode && bus[8]);
    cover property (!chip_select_n && !write_n && word_mode);
endmodule // apc_asserts
`default_nettype wire

//--- test_adc_parallel_port_conv_ctrl.sv
// Purpose: self-checking bench joining host end and converter end
// Assumes: host returns cmd_ready after each command completes
// Notes:   master clock alternates continuous and burst per round
`timescale 1ns/1ps
`default_nettype none
module test_adc_parallel_port_conv_ctrl;
    logic        clk, rst_n, burst, ctrl_strobe;
    logic        master_clk = 1'b0;
    logic        mdiv = 1'b0;
    logic        cmd_valid, cmd_word_mode, cmd_ready, rsp_valid, tracking, powered_up;
    logic [1:0]  cmd_op;
    logic [11:0] cmd_data, rsp_data, ctrl_word, sample_data, got_d, smp, wdat;
    logic [2:0]  rsp_channel, got_c;
    logic [31:0] lfsr;
    int          err_count, num_checks;
    int          n_stb, n_trk, exp_stb, exp_trk;
    apc_if port_if ();
    apc_dev i_apc_dev (.clk(clk), .rst_n(rst_n), .master_clk(master_clk),
        .sample_data(sample_data), .port(port_if), .tracking(tracking),
        .powered_up(powered_up), .ctrl_word(ctrl_word), .ctrl_strobe(ctrl_strobe));
    apc_host i_apc_host (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_word_mode(cmd_word_mode), .port(port_if),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_channel(rsp_channel));
    apc_asserts u_chk (.clk(clk), .rst_n(rst_n), .master_clk(master_clk),
        .conversion_start_n(port_if.conversion_start_n),
        .chip_select_n(port_if.chip_select_n), .read_n(port_if.read_n),
        .write_n(port_if.write_n), .word_mode(port_if.word_mode), .busy(port_if.busy),
        .dev_dout(port_if.dev_dout), .dev_doe(port_if.dev_doe), .bus(port_if.bus));
    // ------------------------------------------------------------
    // clocks; burst mode stops the master clock outside conversions
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        mdiv <= ~mdiv;
        if (burst && !port_if.busy) begin
            master_clk <= 1'b0;
        end else if (mdiv) begin
            master_clk <= ~master_clk;
        end
    end
    // write pulses, and edges where tracking is back while busy still stands
    always @(posedge clk) begin
        if (ctrl_strobe === 1'b1) n_stb++;
        if (port_if.busy === 1'b1 && tracking === 1'b1) n_trk++;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic run(input logic [1:0] op, input logic [11:0] d, input logic wm);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid     <= 1'b1;
        cmd_op        <= op;
        cmd_data      <= d;
        cmd_word_mode <= wm;
        @(posedge clk);
        cmd_valid <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            if (rsp_valid === 1'b1) begin
                got_d = rsp_data;
                got_c = rsp_channel;
            end
            n++;
        end while ((cmd_ready !== 1'b1 || n < 2) && n < 500);
        if (n >= 500) chk("cmd_ready", {11'h000, cmd_ready}, 12'h001);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0; burst = 1'b0;
        cmd_valid = 1'b0; cmd_op = 2'h0; cmd_data = 12'h000; cmd_word_mode = 1'b1;
        sample_data = 12'h000; lfsr = 32'h42DC0880; err_count = 0; num_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            burst <= i[0];
            wdat = {lfsr[11:4], (i == 3), lfsr[2:0]};
            smp = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : lfsr[27:16];
            run(2'h1, wdat, ~i[1]);
            chk("ctrl_word", ctrl_word, wdat);
            exp_stb += i[1] ? 2 : 1;
            chk("ctrl_strobe", 12'(n_stb), 12'(exp_stb));
            sample_data <= smp;
            run(2'h0, 12'h000, 1'b1);
            exp_trk++;
            chk("tracking", {11'h000, tracking}, 12'h001);
            chk("track_busy", 12'(n_trk), 12'(exp_trk));
            chk("powered_up", {11'h000, powered_up}, {11'h000, (i != 3)});
            run(2'h2, 12'h000, ~i[2]);
            chk("read_data", got_d, smp);
            if (!i[2]) chk("data_bit8", {11'h000, got_d[8]}, {11'h000, smp[8]});
            if (i[2]) chk("channel", {9'h000, got_c}, {9'h000, wdat[2:0]});
        end
        test_done();
    end
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule // test_adc_parallel_port_conv_ctrl
`default_nettype wire
